// *** core/cgl_pkg.sv ***
// Shared constants, types and register map of the glue-logic block
package cgl_pkg;
	localparam int NUM_TABLES = 6;
	localparam int NUM_PAIRS  = 3;
	localparam int NUM_INPUTS = 3;

	// Register byte addresses
	localparam logic [11:0] A_MAIN     = 12'h000;
	localparam logic [11:0] A_SEQ0     = 12'h004;
	localparam logic [11:0] A_SEQ_LAST = 12'h00C;
	localparam logic [11:0] A_INT_CTRL = 12'h010;
	localparam logic [11:0] A_INT_FLAG = 12'h014;
	localparam logic [11:0] A_STATUS   = 12'h018;
	localparam logic [11:0] A_TAB0     = 12'h020;
	localparam logic [11:0] A_TAB_LAST = 12'h07C;

	// Field positions
	localparam int CA_ENABLE = 0;
	localparam int CA_CLKSRC = 1;
	localparam int CA_EDGE   = 3;
	localparam int CA_FILT   = 4;
	localparam int SEL_W     = 4;
	localparam int ST_SEQ    = 8;

	// Reset value of all control state
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Output path timing, in table clock edges
	localparam int SYNC_STAGES  = 2;
	localparam int FILTER_AGREE = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		SRC_MASK     = 4'h0,
		SRC_FEEDBACK = 4'h1,
		SRC_LINK     = 4'h2,
		SRC_EVA      = 4'h3,
		SRC_EVB      = 4'h4,
		SRC_PIN      = 4'h5,
		SRC_CMP      = 4'h6,
		SRC_ZC       = 4'h7,
		SRC_SER      = 4'h8,
		SRC_SPI      = 4'h9,
		SRC_TA0      = 4'hA,
		SRC_TA1      = 4'hB,
		SRC_TB       = 4'hC,
		SRC_TD       = 4'hD
	} cgl_src_t;

	typedef enum logic [1:0] {
		FILT_OFF    = 2'h0,
		FILT_SYNC   = 2'h1,
		FILT_FILTER = 2'h2
	} cgl_filt_t;

	typedef enum logic [2:0] {
		SEQ_OFF    = 3'h0,
		SEQ_DFF    = 3'h1,
		SEQ_JK     = 3'h2,
		SEQ_DLATCH = 3'h3,
		SEQ_RS     = 3'h4
	} cgl_seq_t;

	typedef enum logic [1:0] {
		INT_NONE = 2'h0,
		INT_RISE = 2'h1,
		INT_FALL = 2'h2,
		INT_BOTH = 2'h3
	} cgl_int_t;

	typedef enum logic [3:0] {
		K_NONE     = 4'h0,
		K_MAIN     = 4'h1,
		K_SEQ      = 4'h2,
		K_INT_CTRL = 4'h3,
		K_INT_FLAG = 4'h4,
		K_STATUS   = 4'h5,
		K_CA       = 4'h6,
		K_CB       = 4'h7,
		K_CC       = 4'h8,
		K_TR       = 4'h9
	} cgl_kind_t;

	// Inputs from outside the clock domain, synchronised as one group
	typedef struct packed {
		logic [5:0][2:0] pin;
		logic [5:0]      ev_a;
		logic [5:0]      ev_b;
		logic [2:0]      cmp;
		logic [2:0]      zc;
		logic [2:0]      tx;
		logic [2:0]      tx_master;
		logic            spi_master;
		logic            spi_mosi;
		logic            spi_sck;
		logic [2:0]      ta0;
		logic [2:0]      ta1;
		logic [2:0]      tb;
		logic [2:0]      td;
	} cgl_inputs_t;
endpackage

// *** core/cgl_path.sv ***
// Output path of one table: synchroniser, spike filter, edge detector
`timescale 1ns/1ns
module cgl_path (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              en,
	input  wire logic              ce,
	input  wire cgl_pkg::cgl_filt_t filt,
	input  wire logic              edge_en,
	input  wire logic              din,
	output logic                   dout
);
	typedef struct packed {
		logic [2:0] sh;
		logic       filt_out;
		logic       prev;
		logic       pulse;
	} cgl_path_st_t;

	cgl_path_st_t q;
	cgl_path_st_t d;
	logic         lvl;

	always_comb
	begin
		d = q;
		case (filt)
			cgl_pkg::FILT_SYNC:   lvl = q.sh[cgl_pkg::SYNC_STAGES - 1]; // RULE_20
			cgl_pkg::FILT_FILTER: lvl = q.filt_out;
			default:              lvl = din;
		endcase
		if (ce)
		begin
			d.sh = {q.sh[1:0], din};
			// Three agreeing samples before the gate opens
			if (q.sh == 3'h7 || q.sh == 3'h0)
				d.filt_out = q.sh[cgl_pkg::FILTER_AGREE - 1]; // RULE_21
		end
		d.prev  = lvl;
		d.pulse = edge_en & lvl & ~q.prev; // RULE_22
		if (!en)
			d = '0; // RULE_19
		dout = edge_en ? q.pulse : lvl;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_sync_two_edges: assert property ( // RULE_20
		(en && ce && filt == cgl_pkg::FILT_SYNC)[*2]
		|=> dout == $past(din, 2))
		else $error("sync output not two edges late");
	a_filter_holds: assert property ( // RULE_21
		(en && ce && q.sh != 3'h7 && q.sh != 3'h0)
		|=> q.filt_out == $past(q.filt_out))
		else $error("filter passed a short spike");
	a_edge_single: assert property ( // RULE_22
		q.pulse |=> !q.pulse)
		else $error("edge pulse longer than one cycle");
	a_path_cleared: assert property ( // RULE_19
		!en |=> (q == '0))
		else $error("path not cleared after disable");
	c_filter_pass: cover property (
		en && filt == cgl_pkg::FILT_FILTER && !q.filt_out ##1 q.filt_out);
endmodule

// *** core/cgl_top.sv ***
// Six-table programmable glue logic with AXI4-Lite register access
`timescale 1ns/1ns
// Function
// (RULE_01) Six independent tables, three selectable inputs and one output each.
// (RULE_02) Output is truth bit indexed by input 2, input 1, input 0.
// (RULE_03) Select 0x00 ties that input low.
// (RULE_04) Pairs 0-1, 2-3, 4-5 share a sequencer; select 0x01 feeds it back.
// (RULE_05) Select 0x02 takes next table's direct output, last wraps to 0.
// (RULE_06) 0x03/0x04 event channels A/B; 0x05 own pin with same index.
// (RULE_07) 0x06 comparator, 0x07 zero-cross, 0x0C timer B, indexed by input.
// (RULE_08) 0x0A, 0x0B, 0x0D timer A0, A1, D0 waveform outputs.
// (RULE_09) 0x08 serial port transmit line, valid only in clock master mode.
// (RULE_10) 0x09 serial peripheral data to inputs 0,1, clock to 2, master only.
// (RULE_11) Selects 0,1 in control B, select 2 in control C, four bits each.
// (RULE_12) Pair control and sequencer select writable only while even table off.
// (RULE_13) Write setting enable takes protected bits; clearing enable does not.
// (RULE_14) Global enable bit switches whole block on and off.
// (RULE_15) Per-table enable bit in control A.
// (RULE_16) Third pin input may clock the table instead of system clock.
// (RULE_17) Table outputs go to pins and to event network as levels.
// (RULE_18) Interrupt flag on rising, falling or both edges per table.
// (RULE_19) Optional synchroniser, filter and edge detector on each output.
// (RULE_20) Synchroniser output appears after two table clock edges.
// (RULE_21) Filter passes levels lasting over two edges, four edges delay.
// (RULE_22) Edge detector gives one-cycle pulse on each rising edge.
// (RULE_23) Sequencer is D flip-flop, JK flip-flop, D latch or RS latch.
// (RULE_24) Flags stay set until written one; ORed into one request.
// (RULE_25) Global enable low holds outputs, sequencers and flags inactive; flags already set stay set, only new ones are blocked.
module cgl_top (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [5:0][2:0]   table_pin_inputs,
	input  wire logic [5:0]        event_channel_a,
	input  wire logic [5:0]        event_channel_b,
	input  wire logic [2:0]        comparator_input,
	input  wire logic [2:0]        zero_cross_input,
	input  wire logic [2:0]        serial_port_tx_input,
	input  wire logic [2:0]        serial_port_master,
	input  wire logic              spi_master,
	input  wire logic              spi_mosi,
	input  wire logic              spi_sck,
	input  wire logic [2:0]        timer_a0,
	input  wire logic [2:0]        timer_a1,
	input  wire logic [2:0]        timer_b_x,
	input  wire logic [2:0]        timer_d0,
	output logic [5:0]             table_output,
	output logic [5:0]             table_event,
	output logic                   irq,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	typedef struct packed {
		cgl_pkg::cgl_inputs_t s1;
		cgl_pkg::cgl_inputs_t s2;
		logic                 main_en;
		logic [5:0][7:0]      ca;
		logic [5:0][7:0]      cb;
		logic [5:0][7:0]      cc;
		logic [5:0][7:0]      truth;
		logic [2:0][2:0]      sequencer_function_select;
		logic [11:0]          int_ctrl;
		logic [5:0]           flag;
		logic [5:0]           tq;
		logic [5:0]           pin2_prev;
		logic [5:0]           out_prev;
		logic [2:0]           seq;
		logic                 aw_have;
		logic                 w_have;
		logic [11:0]          awaddr;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
	} cgl_state_t;

	cgl_state_t           q;
	cgl_state_t           d;
	cgl_pkg::cgl_inputs_t raw;
	cgl_pkg::cgl_inputs_t sy;
	logic [5:0][2:0]      tin;
	logic [5:0][2:0]      idx_v;
	logic [5:0]           ce_v;
	logic [5:0]           en_v;
	logic [5:0]           pout;
	logic [5:0]           clr_v;
	logic [5:0]           ev_set;
	logic [31:0]          wd;
	logic [2:0]           ti;
	logic [1:0]           si;
	cgl_pkg::cgl_kind_t   wkind;
	cgl_pkg::cgl_kind_t   rkind;

	function automatic cgl_pkg::cgl_kind_t dec_kind(input logic [11:0] a);
		if (a[1:0] != 2'h0)
			return cgl_pkg::K_NONE;
		else if (a == cgl_pkg::A_MAIN)
			return cgl_pkg::K_MAIN;
		else if (a >= cgl_pkg::A_SEQ0 && a <= cgl_pkg::A_SEQ_LAST)
			return cgl_pkg::K_SEQ;
		else if (a == cgl_pkg::A_INT_CTRL)
			return cgl_pkg::K_INT_CTRL;
		else if (a == cgl_pkg::A_INT_FLAG)
			return cgl_pkg::K_INT_FLAG;
		else if (a == cgl_pkg::A_STATUS)
			return cgl_pkg::K_STATUS;
		else if (a >= cgl_pkg::A_TAB0 && a <= cgl_pkg::A_TAB_LAST)
		begin
			if (a[3:2] == 2'h0)
				return cgl_pkg::K_CA;
			else if (a[3:2] == 2'h1)
				return cgl_pkg::K_CB;
			else if (a[3:2] == 2'h2)
				return cgl_pkg::K_CC;
			else
				return cgl_pkg::K_TR;
		end
		else
			return cgl_pkg::K_NONE;
	endfunction

	function automatic logic [2:0] tab_index(input logic [11:0] a);
		logic [11:0] off;
		off = a - cgl_pkg::A_TAB0;
		return off[6:4];
	endfunction

	function automatic logic [31:0] read_reg(input cgl_state_t s,
		input logic [11:0] a, input logic [5:0] outs);
		logic [2:0]  t;
		logic [1:0]  p;
		logic [31:0] r;
		t = tab_index(a);
		p = a[3:2] - 2'h1;
		r = '0;
		case (dec_kind(a))
			cgl_pkg::K_MAIN:     r[0] = s.main_en;
			cgl_pkg::K_SEQ:      r[2:0] = s.sequencer_function_select[p];
			cgl_pkg::K_INT_CTRL: r[11:0] = s.int_ctrl;
			cgl_pkg::K_INT_FLAG: r[5:0] = s.flag;
			cgl_pkg::K_STATUS:
			begin
				r[5:0] = outs;
				r[cgl_pkg::ST_SEQ +: 3] = s.seq;
			end
			cgl_pkg::K_CA:       r[7:0] = s.ca[t];
			cgl_pkg::K_CB:       r[7:0] = s.cb[t];
			cgl_pkg::K_CC:       r[7:0] = s.cc[t];
			cgl_pkg::K_TR:       r[7:0] = s.truth[t];
			default:             r = '0;
		endcase
		return r;
	endfunction

	always_comb
	begin
		raw.pin        = table_pin_inputs;
		raw.ev_a       = event_channel_a;
		raw.ev_b       = event_channel_b;
		raw.cmp        = comparator_input;
		raw.zc         = zero_cross_input;
		raw.tx         = serial_port_tx_input;
		raw.tx_master  = serial_port_master;
		raw.spi_master = spi_master;
		raw.spi_mosi   = spi_mosi;
		raw.spi_sck    = spi_sck;
		raw.ta0        = timer_a0;
		raw.ta1        = timer_a1;
		raw.tb         = timer_b_x;
		raw.td         = timer_d0;
	end

	always_comb
	begin
		d = q;
		sy = q.s2;
		d.s1 = raw;
		d.s2 = q.s1;
		clr_v = '0;
		ev_set = '0;
		wd = '0;
		ti = tab_index(q.awaddr);
		si = q.awaddr[3:2] - 2'h1;
		wkind = dec_kind(q.awaddr);
		rkind = dec_kind(s_axi_araddr[11:0]);
		// Inputs, truth lookup and table clocks
		for (int n = 0; n < cgl_pkg::NUM_TABLES; n++) // RULE_01
		begin
			en_v[n] = q.main_en & q.ca[n][cgl_pkg::CA_ENABLE]; // RULE_14 RULE_15
			// Local clock edge becomes a one-cycle enable
			ce_v[n] = q.ca[n][cgl_pkg::CA_CLKSRC] ?
				(sy.pin[n][2] & ~q.pin2_prev[n]) : 1'h1; // RULE_16
			d.pin2_prev[n] = sy.pin[n][2];
			for (int x = 0; x < cgl_pkg::NUM_INPUTS; x++)
			begin
				case (cgl_pkg::cgl_src_t'((x == 2) ? q.cc[n][3:0] :
					q.cb[n][x * cgl_pkg::SEL_W +: cgl_pkg::SEL_W])) // RULE_11
					cgl_pkg::SRC_FEEDBACK: tin[n][x] = q.seq[n / 2]; // RULE_04
					cgl_pkg::SRC_LINK:
						tin[n][x] = q.tq[(n + 1) % cgl_pkg::NUM_TABLES]; // RULE_05
					cgl_pkg::SRC_EVA: tin[n][x] = sy.ev_a[n]; // RULE_06
					cgl_pkg::SRC_EVB: tin[n][x] = sy.ev_b[n];
					cgl_pkg::SRC_PIN: tin[n][x] = sy.pin[n][x];
					cgl_pkg::SRC_CMP: tin[n][x] = sy.cmp[x]; // RULE_07
					cgl_pkg::SRC_ZC:  tin[n][x] = sy.zc[x];
					cgl_pkg::SRC_SER:
						tin[n][x] = sy.tx[x] & sy.tx_master[x]; // RULE_09
					cgl_pkg::SRC_SPI: // RULE_10
						tin[n][x] = sy.spi_master &
							((x == 2) ? sy.spi_sck : sy.spi_mosi);
					cgl_pkg::SRC_TA0: tin[n][x] = sy.ta0[x]; // RULE_08
					cgl_pkg::SRC_TA1: tin[n][x] = sy.ta1[x];
					cgl_pkg::SRC_TB:  tin[n][x] = sy.tb[x];
					cgl_pkg::SRC_TD:  tin[n][x] = sy.td[x];
					default:          tin[n][x] = 1'h0; // RULE_03
				endcase
			end
			// Input 2 reads low while it serves as the clock
			idx_v[n] = {tin[n][2] & ~q.ca[n][cgl_pkg::CA_CLKSRC],
				tin[n][1], tin[n][0]};
			// Registered so link and feedback chains form no loop
			d.tq[n] = en_v[n] & q.truth[n][idx_v[n]]; // RULE_02
			case (cgl_pkg::cgl_int_t'(q.int_ctrl[2 * n +: 2])) // RULE_18
				cgl_pkg::INT_RISE: ev_set[n] = pout[n] & ~q.out_prev[n];
				cgl_pkg::INT_FALL: ev_set[n] = ~pout[n] & q.out_prev[n];
				cgl_pkg::INT_BOTH: ev_set[n] = pout[n] ^ q.out_prev[n];
				default:           ev_set[n] = 1'h0;
			endcase
			ev_set[n] = ev_set[n] & q.main_en; // RULE_25
		end
		d.out_prev = pout;
		// Sequencers, enabled by the even table; the flip-flops are clocked by it, the latches are not
		for (int p = 0; p < cgl_pkg::NUM_PAIRS; p++)
		begin
			if (!en_v[2 * p])
				d.seq[p] = 1'h0; // RULE_25
			else
				case (cgl_pkg::cgl_seq_t'(q.sequencer_function_select[p])) // RULE_23
					cgl_pkg::SEQ_DFF:
						if (ce_v[2 * p] && pout[2 * p + 1])
							d.seq[p] = pout[2 * p];
					cgl_pkg::SEQ_JK:
						if (ce_v[2 * p])
							case ({pout[2 * p], pout[2 * p + 1]})
								2'h1:    d.seq[p] = 1'h0;
								2'h2:    d.seq[p] = 1'h1;
								2'h3:    d.seq[p] = ~q.seq[p];
								default: d.seq[p] = q.seq[p];
							endcase
					cgl_pkg::SEQ_DLATCH:
						if (pout[2 * p + 1])
							d.seq[p] = pout[2 * p];
					cgl_pkg::SEQ_RS:
						// Both high is forbidden and simply holds
						if (pout[2 * p] && !pout[2 * p + 1])
							d.seq[p] = 1'h1;
						else if (pout[2 * p + 1] && !pout[2 * p])
							d.seq[p] = 1'h0;
					default: d.seq[p] = 1'h0;
				endcase
		end
		// Register writes, once address and data are both held
		if (q.aw_have && q.w_have)
		begin
			wd = read_reg(q, q.awaddr, pout);
			for (int b = 0; b < 4; b++)
				if (q.wstrb[b])
					wd[8 * b +: 8] = q.wdata[8 * b +: 8];
			d.bresp = cgl_pkg::RESP_OKAY;
			case (wkind)
				cgl_pkg::K_MAIN: d.main_en = wd[0]; // RULE_14
				cgl_pkg::K_SEQ:
					if (!q.ca[{si, 1'h0}][cgl_pkg::CA_ENABLE]) // RULE_12
						d.sequencer_function_select[si] = wd[2:0];
				cgl_pkg::K_INT_CTRL: d.int_ctrl = wd[11:0];
				cgl_pkg::K_INT_FLAG:
					clr_v = q.wstrb[0] ? q.wdata[5:0] : 6'h00; // RULE_24
				cgl_pkg::K_STATUS: d.bresp = cgl_pkg::RESP_OKAY;
				cgl_pkg::K_CA:
					if (!q.ca[{ti[2:1], 1'h0}][cgl_pkg::CA_ENABLE] ||
						wd[cgl_pkg::CA_ENABLE]) // RULE_13
						d.ca[ti] = wd[7:0];
					else
						d.ca[ti][cgl_pkg::CA_ENABLE] = 1'h0; // RULE_15
				cgl_pkg::K_CB:
					if (!q.ca[{ti[2:1], 1'h0}][cgl_pkg::CA_ENABLE]) // RULE_12
						d.cb[ti] = wd[7:0];
				cgl_pkg::K_CC:
					if (!q.ca[{ti[2:1], 1'h0}][cgl_pkg::CA_ENABLE]) // RULE_12
						d.cc[ti] = wd[7:0];
				cgl_pkg::K_TR: d.truth[ti] = wd[7:0];
				default: d.bresp = cgl_pkg::RESP_SLVERR;
			endcase
			d.bvalid = 1'h1;
			d.aw_have = 1'h0;
			d.w_have = 1'h0;
		end
		// A new event beats a clear in the same cycle
		d.flag = (q.flag & ~clr_v) | ev_set; // RULE_24
		if (s_axi_awvalid && s_axi_awready)
		begin
			d.aw_have = 1'h1;
			d.awaddr = s_axi_awaddr[11:0];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			d.w_have = 1'h1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'h0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			d.rvalid = 1'h1;
			d.rdata = read_reg(q, s_axi_araddr[11:0], pout);
			d.rresp = (rkind == cgl_pkg::K_NONE) ?
				cgl_pkg::RESP_SLVERR : cgl_pkg::RESP_OKAY;
		end
		else if (q.rvalid && s_axi_rready)
			d.rvalid = 1'h0;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	genvar g;
	generate
		for (g = 0; g < cgl_pkg::NUM_TABLES; g++)
		begin : g_path
			cgl_path u_path (
				.clock   (clock),
				.rst     (rst),
				.en      (en_v[g]),
				.ce      (ce_v[g]),
				.filt    (cgl_pkg::cgl_filt_t'(q.ca[g][cgl_pkg::CA_FILT +: 2])),
				.edge_en (q.ca[g][cgl_pkg::CA_EDGE]),
				.din     (q.tq[g]),
				.dout    (pout[g])
			);
		end
	endgenerate

	assign table_output  = pout; // RULE_17
	assign table_event   = pout;
	assign irq           = |q.flag; // RULE_24
	assign s_axi_awready = !q.aw_have && !q.bvalid;
	assign s_axi_wready  = !q.w_have && !q.bvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_mask_low: assert property ( // RULE_03
		q.cb[0][3:0] == cgl_pkg::SRC_MASK |-> !tin[0][0])
		else $error("masked input not low");
	a_truth_pick: assert property ( // RULE_02
		(en_v[0] && idx_v[0] == 3'h6) |=> q.tq[0] == $past(q.truth[0][6]))
		else $error("truth bit six not selected");
	a_link_feed: assert property ( // RULE_05
		q.cb[5][3:0] == cgl_pkg::SRC_LINK |-> tin[5][0] == q.tq[0])
		else $error("last table not linked to table zero");
	a_protect_hold: assert property ( // RULE_12
		q.ca[0][cgl_pkg::CA_ENABLE] |=> (q.cb[1] == $past(q.cb[1]) &&
			q.sequencer_function_select[0] == $past(q.sequencer_function_select[0])))
		else $error("protected setting changed while enabled");
	a_global_off: assert property ( // RULE_25
		(!q.main_en && $past(!q.main_en)) |-> (pout == '0 && q.seq == '0))
		else $error("outputs active while block disabled");
	a_flag_sticky: assert property ( // RULE_24
		(q.flag[0] && !clr_v[0]) |=> q.flag[0])
		else $error("flag dropped without clear");
	a_flag_rise: assert property ( // RULE_18
		(ev_set[0] && q.int_ctrl[1:0] == cgl_pkg::INT_RISE)
		|=> q.flag[0] && $past(pout[0]) && !$past(q.out_prev[0]))
		else $error("rising edge flag wrong");
	a_seq_dff: assert property ( // RULE_23
		(en_v[0] && q.sequencer_function_select[0] == cgl_pkg::SEQ_DFF && ce_v[0] && pout[1])
		|=> q.seq[0] == $past(pout[0]))
		else $error("gated flip-flop did not follow data");
	c_jk_toggle: cover property (
		q.sequencer_function_select[0] == cgl_pkg::SEQ_JK && q.seq[0] ##1 !q.seq[0]);
	c_flag_set: cover property (!q.flag[0] ##1 q.flag[0]);
	c_axi_write: cover property (q.bvalid && s_axi_bready);
endmodule

// *** dv/cgl_far.sv ***
// Far-side model: pins, event channels and peripheral outputs
`timescale 1ns/1ns
module cgl_far (
	input  wire logic        clock,
	input  wire logic [2:0]  vec,
	input  wire logic        master,
	output logic [5:0][2:0]  table_pin_inputs,
	output logic [5:0]       event_channel_a,
	output logic [5:0]       event_channel_b,
	output logic [2:0]       comparator_input,
	output logic [2:0]       zero_cross_input,
	output logic [2:0]       serial_port_tx_input,
	output logic [2:0]       serial_port_master,
	output logic             spi_master,
	output logic             spi_mosi,
	output logic             spi_sck,
	output logic [2:0]       timer_a0,
	output logic [2:0]       timer_a1,
	output logic [2:0]       timer_b_x,
	output logic [2:0]       timer_d0
);
	logic [2:0] v_q = 3'h0;
	logic       m_q = 1'b0;

	always @(posedge clock)
	begin
		v_q <= vec;
		m_q <= master;
	end

	// One pattern on every source keeps the expectation simple
	assign table_pin_inputs     = {6{v_q}};
	assign event_channel_a      = {6{v_q[0]}};
	assign event_channel_b      = {6{v_q[1]}};
	assign comparator_input     = v_q;
	assign zero_cross_input     = v_q;
	// Lines keep toggling when not master: the block must gate them
	assign serial_port_tx_input = v_q;
	assign serial_port_master   = {3{m_q}};
	assign spi_master           = m_q;
	assign spi_mosi             = v_q[0];
	assign spi_sck              = v_q[2];
	assign timer_a0             = v_q;
	assign timer_a1             = v_q;
	assign timer_b_x            = v_q;
	assign timer_d0             = v_q;
endmodule

// *** dv/configurable_lut_logic_tb.sv ***
// Self-checking bench of the glue-logic block
`timescale 1ns/1ns
module configurable_lut_logic_tb;
	localparam logic [1:0] OK  = cgl_pkg::RESP_OKAY;
	localparam logic [1:0] SLV = cgl_pkg::RESP_SLVERR;
	logic                  clock = 1'b0;
	logic                  rst = 1'b1;
	logic [2:0]            vec = 3'h0;
	logic                  master = 1'b0;
	logic [31:0]           awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic                  awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic                  bready = 1'b0, rready = 1'b0;
	logic                  awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]            bresp, rresp;
	logic [5:0][2:0]       table_pin_inputs;
	logic [5:0]            event_channel_a, event_channel_b;
	logic [5:0]            table_output, table_event;
	logic [2:0]            comparator_input, zero_cross_input, timer_a0;
	logic [2:0]            serial_port_tx_input, serial_port_master;
	logic [2:0]            timer_a1, timer_b_x, timer_d0;
	logic                  spi_master, spi_mosi, spi_sck;
	logic [33:0]           rq[$], bq[$];
	logic [3:0]            srcs[12] = '{0, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13};
	logic [3:0]            s0, s1, s2;
	logic [7:0]            t;
	int                    fails = 0, compares = 0, seed = 43;

	always #2 clock = ~clock;

	cgl_far i_far (.clock, .vec, .master, .table_pin_inputs,
		.event_channel_a, .event_channel_b, .comparator_input,
		.zero_cross_input, .serial_port_tx_input, .serial_port_master,
		.spi_master, .spi_mosi, .spi_sck, .timer_a0, .timer_a1,
		.timer_b_x, .timer_d0);

	cgl_top i_dut (.clock, .rst, .table_pin_inputs, .event_channel_a,
		.event_channel_b, .comparator_input, .zero_cross_input,
		.serial_port_tx_input, .serial_port_master, .spi_master, .spi_mosi,
		.spi_sck, .timer_a0, .timer_a1, .timer_b_x, .timer_d0,
		.table_output, .table_event, .irq,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp)
		begin
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			fails++;
		end
	endtask

	task automatic summarize;
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bq.push_back({32'h0, r});
		@(posedge clock);
		awaddr <= {20'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!(bvalid && bready));
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] r);
		rq.push_back({r, e});
		@(posedge clock);
		araddr <= {20'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!(rvalid && rready));
		rready <= 1'b0;
	endtask

	// Disable first: selects are only taken while the even table is off
	task automatic cfg(input int n, input logic [3:0] a, b, c,
		input logic [7:0] tr, input logic [7:0] ca);
		logic [11:0] base;
		base = cgl_pkg::A_TAB0 + 12'(n * 16);
		wr(base, 32'h0, OK);
		wr(base + 12'h4, {24'h0, b, a}, OK);
		wr(base + 12'h8, {28'h0, c}, OK);
		wr(base + 12'hC, {24'h0, tr}, OK);
		wr(base, {24'h0, ca}, OK);
	endtask

	function automatic logic exp_out(input logic [3:0] a, b, c,
		input logic [7:0] tr, input logic [2:0] v, input logic m);
		logic [3:0] s[3];
		logic [2:0] i;
		s = '{a, b, c};
		for (int x = 0; x < 3; x++)
			case (s[x])
				4'h0: i[x] = 1'b0;
				4'h3: i[x] = v[0];
				4'h4: i[x] = v[1];
				4'h8: i[x] = m & v[x];
				4'h9: i[x] = m & v[x == 2 ? 2 : 0];
				default: i[x] = v[x];
			endcase
		return tr[i];
	endfunction

	always @(posedge clock)
	begin
		if (rvalid && rready)
			check({rresp, rdata}, rq.pop_front());
		if (bvalid && bready)
			check({32'h0, bresp}, bq.pop_front());
		if (!rst && table_event !== table_output)
			check({28'h0, table_event}, {28'h0, table_output});
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		fails++;
		summarize();
	end

	initial
	begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		rd(cgl_pkg::A_MAIN, 32'h0, OK);
		rd(12'h01C, 32'h0, SLV);
		wr(12'h002, 32'h1, SLV);
		wr(cgl_pkg::A_MAIN, 32'h1, OK);
		for (int k = 0; k < 36; k++)
		begin
			s0 = srcs[k % 12];
			s1 = srcs[(k + 5) % 12];
			s2 = srcs[(k + 7) % 12];
			t = 8'($random(seed));
			vec <= 3'($random(seed));
			master <= 1'($random(seed));
			cfg(0, s0, s1, s2, t, 8'h01);
			repeat (6) @(posedge clock);
			rd(cgl_pkg::A_STATUS, {31'h0, exp_out(s0, s1, s2, t, vec,
				master)}, OK);
		end
		// Table 0 still enabled: pair configuration is locked
		wr(cgl_pkg::A_SEQ0, 32'h1, OK);
		rd(cgl_pkg::A_SEQ0, 32'h0, OK);
		wr(cgl_pkg::A_TAB0 + 12'h4, 32'h0, OK);
		rd(cgl_pkg::A_TAB0 + 12'h4, {24'h0, s1, s0}, OK);
		wr(cgl_pkg::A_TAB0, 32'h20, OK);
		rd(cgl_pkg::A_TAB0, 32'h0, OK);
		wr(cgl_pkg::A_TAB0, 32'h11, OK);
		rd(cgl_pkg::A_TAB0, 32'h11, OK);
		cfg(1, 4'h0, 4'h0, 4'h0, 8'hFF, 8'h01);
		cfg(0, 4'h2, 4'h0, 4'h0, 8'h02, 8'h01);
		cfg(5, 4'h2, 4'h0, 4'h0, 8'h02, 8'h01);
		repeat (10) @(posedge clock);
		rd(cgl_pkg::A_STATUS, 32'h23, OK);
		// Table 0 falls, then rises: only the rise may raise its flag
		wr(cgl_pkg::A_INT_CTRL, 32'h1, OK);
		wr(cgl_pkg::A_TAB0 + 12'hC, 32'h0, OK);
		repeat (4) @(posedge clock);
		rd(cgl_pkg::A_INT_FLAG, 32'h0, OK);
		wr(cgl_pkg::A_TAB0 + 12'hC, 32'h2, OK);
		repeat (4) @(posedge clock);
		rd(cgl_pkg::A_INT_FLAG, 32'h1, OK);
		check({33'h0, irq}, 34'h1);
		wr(cgl_pkg::A_INT_FLAG, 32'h1, OK);
		rd(cgl_pkg::A_INT_FLAG, 32'h0, OK);
		check({33'h0, irq}, 34'h0);
		wr(cgl_pkg::A_MAIN, 32'h0, OK);
		repeat (6) @(posedge clock);
		rd(cgl_pkg::A_STATUS, 32'h0, OK);
		repeat (2) @(posedge clock);
		summarize();
	end
endmodule
